// File: rtl/mmac_defines.svh
// Register offsets, field positions, reset values and counts of the acquisition block.
`ifndef MMAC_DEFINES_SVH
`define MMAC_DEFINES_SVH

`define MMAC_ADDR_W 20
`define MMAC_OFS_MODE 20'h00000
`define MMAC_OFS_CTRL 20'h00004
`define MMAC_OFS_PRETRIG 20'h00008
`define MMAC_OFS_WINLEN 20'h0000C
`define MMAC_OFS_STATUS 20'h00010
`define MMAC_OFS_IRQ_STAT 20'h00014
`define MMAC_OFS_IRQ_MASK 20'h00018
`define MMAC_OFS_RD_ADDR 20'h0001C
`define MMAC_OFS_RD_DATA 20'h00020

`define MMAC_MODE_CH1 0
`define MMAC_MODE_CH2 1
`define MMAC_MODE_XY 2
`define MMAC_MODE_PEAK 3
`define MMAC_MODE_SWAP 4
`define MMAC_MODE_TEST 5
`define MMAC_MODE_RST 6'h01

`define MMAC_CTRL_ARM 0
`define MMAC_CTRL_LEN4K 1
`define MMAC_CTRL_SRST 2

`define MMAC_ST_FILLED 0
`define MMAC_ST_DONE 1
`define MMAC_ST_RUN 2
`define MMAC_ST_LOC_LSB 16

`define MMAC_IRQ_FILLED 0
`define MMAC_IRQ_TRIG 1
`define MMAC_IRQ_DONE 2

`define MMAC_PAIRS_4K 12'h800
`define MMAC_PAIRS_1K 12'h200
`define MMAC_WINLEN_RST 8'h01

`endif

// File: rtl/mmac_pkg.sv
// Types shared by the acquisition capture modules.
package mmac_pkg;

    typedef enum logic [1:0] {
        MMAC_SMODE_RECORD,
        MMAC_SMODE_PEAK,
        MMAC_SMODE_XY
    } mmac_smode_t;

    typedef enum logic [1:0] {
        MMAC_ACQ_IDLE,
        MMAC_ACQ_PRE,
        MMAC_ACQ_WAIT_TRIG,
        MMAC_ACQ_POST
    } mmac_acq_t;

    function automatic logic [31:0] mmac_be_merge(input logic [31:0] old_v,
                                                  input logic [31:0] new_v,
                                                  input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : mmac_be_merge

endpackage : mmac_pkg

// File: rtl/mmac_hold_pair.sv
// Minimum and maximum holding registers with their two magnitude comparators.
`timescale 1ns/1ps
module mmac_hold_pair (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic clr,
    input mmac_pkg::mmac_smode_t smode,
    input wire logic [7:0] sample,
    input wire logic sample_vld,
    input wire logic first_in_win,
    input wire logic phase_hi,
    output logic [7:0] min_val,
    output logic [7:0] max_val,
    output logic lower_sample_strobe,
    output logic higher_sample_strobe,
    output logic low_hold_clock,
    output logic high_hold_clock
);
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
    } mmac_hold_t;

    mmac_hold_t s_q;
    mmac_hold_t s_d;
    logic peak;

    always_comb begin
        s_d = s_q;
        peak = (smode == mmac_pkg::MMAC_SMODE_PEAK);
        // Unsigned compare; equal values are not news.
        lower_sample_strobe = sample_vld && peak && !first_in_win && (sample < s_q.lo);
        higher_sample_strobe = sample_vld && peak && !first_in_win && (sample > s_q.hi);
        if (peak) begin
            low_hold_clock = sample_vld && (first_in_win || lower_sample_strobe);
            high_hold_clock = sample_vld && (first_in_win || higher_sample_strobe);
        end else begin
            // Record: alternate phases. X-Y: channel one low, channel two high.
            low_hold_clock = sample_vld && !phase_hi;
            high_hold_clock = sample_vld && phase_hi;
        end
        if (low_hold_clock) begin
            s_d.lo = sample;
        end
        if (high_hold_clock) begin
            s_d.hi = sample;
        end
        if (clr) begin
            s_d = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign min_val = s_q.lo;
    assign max_val = s_q.hi;

endmodule : mmac_hold_pair

// File: rtl/mmac_acq_ram.sv
// One byte-wide acquisition RAM with a clocked write and an unclocked read.
`timescale 1ns/1ps
module mmac_acq_ram #(
    parameter int AW = 11
) (
    input wire logic clk_sys,
    input wire logic clk_en,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    // Contents are not reset; software reads only what an acquisition wrote.
    logic [7:0] mem [0:(1<<AW)-1];

    if (AW < 2 || AW > 16) begin : g_chk
        $error("mmac_acq_ram: unsupported address width");
    end

    always_ff @(posedge clk_sys) begin
        if (clk_en && we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule : mmac_acq_ram

// File: rtl/mmac_acq_capture.sv
// Min/max acquisition path: input buffer, holding pair, swap stage, odd/even RAMs, counters.
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "mmac_defines.svh"
// Functional notes
// - Each buffered sample feeds a minimum and a maximum register, each separately clocked.
// - Two eight-bit comparators check samples against held minimum and held maximum.
// - Peak-detect loads the first sample of every window into both registers.
// - Peak-detect strobes lower or higher sample news, clocking the sample in.
// - At each peak window end, min and max move into the swap registers.
// - Record sampling loads samples alternately into min and max, no comparing.
// - X-Y mode: channel one goes to min, channel two to max.
// - Four swap registers: max loads two in parallel, min loads two.
// - Swap control routes min and max to the opposite memory buses.
// - Host writes a latched mode register; the block acts on its bits.
// - Stage strobes move samples buffer, hold, swap, memory as a pipeline.
// - Test mode replaces converter data with a diagnostic counter.
// - Storage is two 2K-by-8 RAMs, odd bytes and even bytes.
// - Preloaded pretrigger count raises a filled flag that enables trigger acceptance.
// - Remaining address counter bits address the acquisition memories.
// - Host bus has twenty address lines, low eight also carrying data; here data moves on separate 32-bit avs_writedata and avs_readdata.
// - Count stores, flag record done, 4K or 1K, one or two channels.
module mmac_acq_capture #(
    parameter int LOC_W = 11
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [`MMAC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] adc_data,
    input wire logic adc_vld,
    input wire logic adc_chan2,
    input wire logic trig_in,
    output logic lower_sample_strobe,
    output logic higher_sample_strobe,
    output logic low_hold_clock,
    output logic high_hold_clock,
    output logic alternate_phase_clock,
    output logic pretrigger_filled,
    output logic record_done_flag,
    output logic irq
);
    typedef struct packed {
        logic [5:0] mode;
        logic len4k;
        logic [LOC_W-1:0] pretrig;
        logic [7:0] winlen;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [LOC_W:0] rd_addr;
        logic rd_ack;
        logic [31:0] rdata;
        logic [7:0] buf_v;
        logic buf_vld;
        logic buf_first;
        logic buf_hi;
        logic buf_last;
        logic [7:0] test_cnt;
        logic [7:0] win_cnt;
        logic phase;
        logic xfer;
        logic [7:0] swap_max_a;
        logic [7:0] swap_max_b;
        logic [7:0] swap_min_a;
        logic [7:0] swap_min_b;
        logic swap_flip;
        logic wr_pend;
        logic [LOC_W-1:0] loc;
        logic [LOC_W-1:0] pre_cnt;
        logic filled;
        logic [LOC_W:0] post_cnt;
        logic done;
        mmac_pkg::mmac_acq_t acq;
    } mmac_state_t;

    if (LOC_W != 11) begin : g_chk
        $error("mmac_acq_capture: record lengths need 2K locations per RAM");
    end

    mmac_state_t s_q;
    mmac_state_t s_d;
    mmac_pkg::mmac_smode_t smode;
    logic [7:0] min_val;
    logic [7:0] max_val;
    logic [7:0] even_bus;
    logic [7:0] odd_bus;
    logic [7:0] even_rd;
    logic [7:0] odd_rd;
    logic wr_ok;
    logic soft_rst;
    logic running;
    logic last_in_win;
    logic [7:0] smp;
    logic [LOC_W:0] rec_pairs;
    logic [LOC_W:0] post_len;
    logic [31:0] wmask;

    // Mode decode from the latched register bits only.
    always_comb begin
        if (s_q.mode[`MMAC_MODE_XY]) begin
            smode = mmac_pkg::MMAC_SMODE_XY;
        end else if (s_q.mode[`MMAC_MODE_PEAK]) begin
            smode = mmac_pkg::MMAC_SMODE_PEAK;
        end else begin
            smode = mmac_pkg::MMAC_SMODE_RECORD;
        end
    end

    mmac_hold_pair u_hold (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .clr(soft_rst),
        .smode(smode),
        .sample(s_q.buf_v),
        .sample_vld(s_q.buf_vld),
        .first_in_win(s_q.buf_first),
        .phase_hi(s_q.buf_hi),
        .min_val(min_val),
        .max_val(max_val),
        .lower_sample_strobe(lower_sample_strobe),
        .higher_sample_strobe(higher_sample_strobe),
        .low_hold_clock(low_hold_clock),
        .high_hold_clock(high_hold_clock)
    );

    // Normal order puts min on the even bus; the alternate swap registers reverse it.
    assign even_bus = s_q.swap_flip ? s_q.swap_max_b : s_q.swap_min_a;
    assign odd_bus = s_q.swap_flip ? s_q.swap_min_b : s_q.swap_max_a;

    mmac_acq_ram #(
        .AW(LOC_W)
    ) u_ram_even (
        .clk_sys(clk_sys),
        .clk_en(clk_en),
        .we(s_q.wr_pend),
        .waddr(s_q.loc),
        .wdata(even_bus),
        .raddr(s_q.rd_addr[LOC_W:1]),
        .rdata(even_rd)
    );

    mmac_acq_ram #(
        .AW(LOC_W)
    ) u_ram_odd (
        .clk_sys(clk_sys),
        .clk_en(clk_en),
        .we(s_q.wr_pend),
        .waddr(s_q.loc),
        .wdata(odd_bus),
        .raddr(s_q.rd_addr[LOC_W:1]),
        .rdata(odd_rd)
    );

    // Every read waits one cycle so that read data always comes from a flip-flop.
    assign wr_ok = clk_en && avs_write && !avs_read;
    assign soft_rst = wr_ok && (avs_address == `MMAC_OFS_CTRL) && avs_byteenable[0]
                      && avs_writedata[`MMAC_CTRL_SRST];
    assign avs_waitrequest = !clk_en || (avs_read && !s_q.rd_ack);
    assign avs_readdata = s_q.rdata;

    assign running = (s_q.acq != mmac_pkg::MMAC_ACQ_IDLE);
    assign alternate_phase_clock = s_q.phase;
    assign pretrigger_filled = s_q.filled;
    assign record_done_flag = s_q.done;
    assign irq = |(s_q.irq_stat & s_q.irq_mask);

    always_comb begin
        s_d = s_q;
        wmask = '0;
        // A one clears; events are applied further down, so a set in the same cycle wins.
        if (wr_ok && avs_address == `MMAC_OFS_IRQ_STAT) begin
            s_d.irq_stat = s_q.irq_stat & ~(avs_writedata[2:0] & {3{avs_byteenable[0]}});
        end
        smp = s_q.mode[`MMAC_MODE_TEST] ? s_q.test_cnt : adc_data;
        last_in_win = (s_q.win_cnt + 8'h01 >= s_q.winlen);
        // Two channels share the record, so each gets half.
        rec_pairs = s_q.len4k ? `MMAC_PAIRS_4K : `MMAC_PAIRS_1K;
        if (s_q.mode[`MMAC_MODE_CH1] && s_q.mode[`MMAC_MODE_CH2]) begin
            rec_pairs = rec_pairs >> 1;
        end
        // A pretrigger at or above the record leaves one post-trigger pair.
        if ({1'b0, s_q.pretrig} >= rec_pairs) begin
            post_len = 12'h001;
        end else begin
            post_len = rec_pairs - {1'b0, s_q.pretrig};
        end

        // Stage 1: input buffer, fed by the converter or the test counter.
        s_d.buf_vld = 1'b0;
        if (adc_vld && running) begin
            s_d.buf_v = smp;
            s_d.buf_vld = 1'b1;
            if (s_q.mode[`MMAC_MODE_TEST]) begin
                s_d.test_cnt = s_q.test_cnt + 8'h01;
            end
            case (smode)
                mmac_pkg::MMAC_SMODE_PEAK: begin
                    s_d.buf_first = (s_q.win_cnt == 8'h00);
                    s_d.buf_hi = 1'b0;
                    s_d.buf_last = last_in_win;
                    s_d.win_cnt = last_in_win ? 8'h00 : s_q.win_cnt + 8'h01;
                end
                mmac_pkg::MMAC_SMODE_XY: begin
                    s_d.buf_first = 1'b0;
                    s_d.buf_hi = adc_chan2;
                    s_d.buf_last = adc_chan2;
                end
                default: begin
                    s_d.buf_first = 1'b0;
                    s_d.buf_hi = s_q.phase;
                    s_d.buf_last = s_q.phase;
                    s_d.phase = !s_q.phase;
                end
            endcase
        end

        // Stage 2 is the holding pair; mark a complete pair for the swap stage.
        s_d.xfer = s_q.buf_vld && s_q.buf_last;

        // Stage 3: both copies of max and of min load in parallel.
        s_d.wr_pend = s_q.xfer;
        if (s_q.xfer) begin
            s_d.swap_max_a = max_val;
            s_d.swap_max_b = max_val;
            s_d.swap_min_a = min_val;
            s_d.swap_min_b = min_val;
            s_d.swap_flip = s_q.mode[`MMAC_MODE_SWAP];
        end

        // Stage 4: memory write, then the address and record counters.
        if (s_q.wr_pend) begin
            s_d.loc = s_q.loc + 11'h001;
            case (s_q.acq)
                mmac_pkg::MMAC_ACQ_PRE: begin
                    s_d.pre_cnt = s_q.pre_cnt - 11'h001;
                    if (s_q.pre_cnt <= 11'h001) begin
                        s_d.filled = 1'b1;
                        s_d.irq_stat[`MMAC_IRQ_FILLED] = 1'b1;
                        s_d.acq = mmac_pkg::MMAC_ACQ_WAIT_TRIG;
                    end
                end
                mmac_pkg::MMAC_ACQ_POST: begin
                    s_d.post_cnt = s_q.post_cnt + 12'h001;
                    if (s_q.post_cnt + 12'h001 >= post_len) begin
                        s_d.done = 1'b1;
                        s_d.irq_stat[`MMAC_IRQ_DONE] = 1'b1;
                        s_d.acq = mmac_pkg::MMAC_ACQ_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
        // A trigger counts only once the pretrigger part is full.
        if (s_q.acq == mmac_pkg::MMAC_ACQ_WAIT_TRIG && trig_in && s_q.filled) begin
            s_d.acq = mmac_pkg::MMAC_ACQ_POST;
            s_d.post_cnt = '0;
            s_d.irq_stat[`MMAC_IRQ_TRIG] = 1'b1;
        end

        // Bus read: capture on the first cycle, release on the second.
        s_d.rd_ack = clk_en && avs_read && !s_q.rd_ack;
        if (avs_read && !s_q.rd_ack) begin
            case (avs_address)
                `MMAC_OFS_MODE: s_d.rdata = {26'h0000000, s_q.mode};
                `MMAC_OFS_CTRL: s_d.rdata = {30'h00000000, s_q.len4k, 1'b0};
                `MMAC_OFS_PRETRIG: s_d.rdata = {21'h000000, s_q.pretrig};
                `MMAC_OFS_WINLEN: s_d.rdata = {24'h000000, s_q.winlen};
                `MMAC_OFS_STATUS: s_d.rdata = {5'h00, s_q.loc, 13'h0000, running,
                                               s_q.done, s_q.filled};
                `MMAC_OFS_IRQ_STAT: s_d.rdata = {29'h00000000, s_q.irq_stat};
                `MMAC_OFS_IRQ_MASK: s_d.rdata = {29'h00000000, s_q.irq_mask};
                `MMAC_OFS_RD_ADDR: s_d.rdata = {20'h00000, s_q.rd_addr};
                `MMAC_OFS_RD_DATA: s_d.rdata = {24'h000000,
                                                s_q.rd_addr[0] ? odd_rd : even_rd};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (clk_en && avs_read && s_q.rd_ack && avs_address == `MMAC_OFS_RD_DATA) begin
            s_d.rd_addr = s_q.rd_addr + 12'h001;
        end

        // Bus write; only the low twenty address lines are decoded.
        if (wr_ok) begin
            case (avs_address)
                `MMAC_OFS_MODE: begin
                    if (avs_byteenable[0]) begin
                        s_d.mode = avs_writedata[5:0];
                    end
                end
                `MMAC_OFS_CTRL: begin
                    if (avs_byteenable[0]) begin
                        s_d.len4k = avs_writedata[`MMAC_CTRL_LEN4K];
                        if (avs_writedata[`MMAC_CTRL_ARM]) begin
                            s_d.acq = (s_q.pretrig == '0) ? mmac_pkg::MMAC_ACQ_WAIT_TRIG
                                                          : mmac_pkg::MMAC_ACQ_PRE;
                            s_d.pre_cnt = s_q.pretrig;
                            s_d.filled = (s_q.pretrig == '0);
                            s_d.done = 1'b0;
                            s_d.post_cnt = '0;
                            s_d.win_cnt = 8'h00;
                            s_d.phase = 1'b0;
                        end
                    end
                end
                `MMAC_OFS_PRETRIG: begin
                    wmask = mmac_pkg::mmac_be_merge({21'h0, s_q.pretrig}, avs_writedata,
                                                    avs_byteenable);
                    s_d.pretrig = wmask[LOC_W-1:0];
                end
                `MMAC_OFS_WINLEN: begin
                    if (avs_byteenable[0]) begin
                        s_d.winlen = avs_writedata[7:0];
                    end
                end
                `MMAC_OFS_IRQ_MASK: begin
                    if (avs_byteenable[0]) begin
                        s_d.irq_mask = avs_writedata[2:0];
                    end
                end
                `MMAC_OFS_RD_ADDR: begin
                    wmask = mmac_pkg::mmac_be_merge({20'h0, s_q.rd_addr}, avs_writedata,
                                                    avs_byteenable);
                    s_d.rd_addr = wmask[LOC_W:0];
                end
                default: begin
                end
            endcase
            if (soft_rst) begin
                s_d.mode = `MMAC_MODE_RST;
                s_d.buf_vld = 1'b0;
                s_d.xfer = 1'b0;
                s_d.wr_pend = 1'b0;
                s_d.swap_max_a = 8'h00;
                s_d.swap_max_b = 8'h00;
                s_d.swap_min_a = 8'h00;
                s_d.swap_min_b = 8'h00;
                s_d.loc = '0;
                s_d.pre_cnt = '0;
                s_d.post_cnt = '0;
                s_d.filled = 1'b0;
                s_d.done = 1'b0;
                s_d.acq = mmac_pkg::MMAC_ACQ_IDLE;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.mode <= `MMAC_MODE_RST;
            s_q.winlen <= `MMAC_WINLEN_RST;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

endmodule : mmac_acq_capture

// File: verification/mmac_acq_capture_props.sv
// Port-level assertions for the acquisition capture block.
`timescale 1ns/1ps
module mmac_acq_props (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic adc_vld,
    input wire logic lower_sample_strobe,
    input wire logic higher_sample_strobe,
    input wire logic low_hold_clock,
    input wire logic high_hold_clock,
    input wire logic alternate_phase_clock,
    input wire logic pretrigger_filled,
    input wire logic record_done_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_stall_waits: assert property (!clk_en |-> avs_waitrequest)
        else $error("waitrequest low while clock enable is low");
    a_write_nowait: assert property (clk_en && avs_write && !avs_read |-> !avs_waitrequest)
        else $error("write was made to wait");
    a_read_answer: assert property (clk_en && avs_read && !avs_write |-> ##[0:1] !avs_waitrequest)
        else $error("read not answered within two cycles");
    a_read_waits: assert property ($rose(avs_read) && clk_en |-> avs_waitrequest)
        else $error("read answered in its first cycle");
    a_min_strobe: assert property (lower_sample_strobe |-> low_hold_clock && !higher_sample_strobe)
        else $error("lower strobe without minimum load");
    a_max_strobe: assert property (higher_sample_strobe |-> high_hold_clock)
        else $error("higher strobe without maximum load");
    a_hold_cause: assert property ((low_hold_clock || high_hold_clock) && $past(clk_en) |-> $past(adc_vld))
        else $error("holding register loaded without a sample");
    a_done_after_fill: assert property ($rose(record_done_flag) |-> $past(pretrigger_filled))
        else $error("record finished before pretrigger filled");
    a_done_stays: assert property (record_done_flag && !avs_write |=> record_done_flag)
        else $error("record done dropped without a host write");
    a_phase_moves: assert property ($changed(alternate_phase_clock)
        |-> $past(adc_vld) || $past(avs_write)) else $error("record phase moved without a sample");
    cover property (lower_sample_strobe);
    cover property (higher_sample_strobe);
    cover property ($rose(record_done_flag));
endmodule : mmac_acq_props

bind mmac_acq_capture mmac_acq_props mmac_acq_props_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .clk_en(clk_en), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .adc_vld(adc_vld), .lower_sample_strobe(lower_sample_strobe),
    .higher_sample_strobe(higher_sample_strobe), .low_hold_clock(low_hold_clock),
    .high_hold_clock(high_hold_clock), .alternate_phase_clock(alternate_phase_clock),
    .pretrigger_filled(pretrigger_filled),
    .record_done_flag(record_done_flag));

// File: verification/mmac_adc_model.sv
// Converter source that emits random samples with random gaps.
`timescale 1ns/1ps
module mmac_adc_model (
    input wire logic clk_sys,
    input wire logic en,
    output logic [7:0] adc_data,
    output logic adc_vld,
    output logic adc_chan2
);
    int seed = 32'h9385;
    logic [31:0] r;
    initial begin
        adc_data = 8'h00;
        adc_vld = 1'b0;
        adc_chan2 = 1'b0;
    end
    // Data changes every cycle so that nothing may rely on a stale byte.
    always @(posedge clk_sys) begin
        r = $random(seed);
        adc_vld <= en & r[0];
        adc_data <= r[15:8];
        adc_chan2 <= en & (adc_chan2 ^ adc_vld);
    end
endmodule : mmac_adc_model

// File: verification/testbench.sv
// Self-checking bench for the min/max acquisition capture block.
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic trig_in = 1'b0;
    logic adc_en = 1'b0;
    logic [19:0] avs_address = 20'h00000;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata, rd;
    logic [7:0] adc_data;
    logic avs_waitrequest, adc_vld, adc_chan2, filled, done, irq;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] smp[$];
    always #2.5 clk_sys = ~clk_sys;
    mmac_adc_model mmac_adc_model_inst (.clk_sys(clk_sys), .en(adc_en), .adc_data(adc_data),
        .adc_vld(adc_vld), .adc_chan2(adc_chan2));
    mmac_acq_capture mmac_acq_capture_inst (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .adc_data(adc_data), .adc_vld(adc_vld),
        .adc_chan2(adc_chan2), .trig_in(trig_in), .lower_sample_strobe(), .higher_sample_strobe(),
        .low_hold_clock(), .high_hold_clock(), .alternate_phase_clock(),
        .pretrigger_filled(filled), .record_done_flag(done), .irq(irq));
    task wrap_up;
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Waitrequest and read data are taken at the rising edge, before that edge updates them.
    task bus(input logic wr, input logic [19:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task run(input logic [5:0] mode, input logic [7:0] win);
        int s, b;
        logic [7:0] lo, hi, e;
        trig_in <= 1'b0;
        bus(1'b1, 20'h00004, 32'h00000004);
        bus(1'b1, 20'h00000, {26'h0, mode});
        bus(1'b1, 20'h0000C, {24'h0, win});
        bus(1'b1, 20'h00008, 32'h00000004);
        bus(1'b1, 20'h00018, 32'h00000007);
        smp.delete();
        bus(1'b1, 20'h00004, 32'h00000001);
        adc_en <= 1'b1;
        while (done !== 1'b1) begin
            @(posedge clk_sys);
            if (filled === 1'b1) trig_in <= 1'b1;
        end
        adc_en <= 1'b0;
        bus(1'b0, 20'h00014, 32'h0);
        check("irq_stat", rd, 32'h00000007);
        check("irq_up", {31'h0, irq}, 32'h1);
        bus(1'b1, 20'h00018, 32'h00000000);
        check("irq_masked", {31'h0, irq}, 32'h0);
        bus(1'b1, 20'h00014, 32'h00000007);
        bus(1'b1, 20'h00018, 32'h00000007);
        check("irq_clear", {31'h0, irq}, 32'h0);
        bus(1'b1, 20'h0001C, 32'h00000000);
        s = mode[3] ? ((win == 8'h00) ? 1 : int'(win)) : 2;
        for (int k = 0; k < 8; k++) begin
            b = (k / 2) * s;
            lo = smp[b];
            hi = mode[3] ? smp[b] : smp[b + 1];
            for (int n = 1; n < s && mode[3]; n++) begin
                if (smp[b + n] < lo) lo = smp[b + n];
                if (smp[b + n] > hi) hi = smp[b + n];
            end
            bus(1'b0, 20'h00020, 32'h0);
            e = mode[5] ? k[7:0] : ((k[0] ^ mode[4]) ? hi : lo);
            check("ram", rd, {24'h0, e});
        end
    endtask : run
    always @(posedge clk_sys) begin
        if (adc_vld && clk_en) smp.push_back(adc_data);
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        clk_en <= 1'b1;
        @(posedge clk_sys);
        bus(1'b0, 20'h00000, 32'h0);
        check("mode_reset", rd, 32'h00000001);
        bus(1'b0, 20'h00040, 32'h0);
        check("unmapped", rd, 32'h00000000);
        run(6'h01, 8'h01);
        run(6'h09, 8'h04);
        run(6'h19, 8'h00);
        run(6'h07, 8'h01);
        run(6'h11, 8'h00);
        run(6'h21, 8'h01);
        bus(1'b1, 20'h00004, 32'h00000004);
        bus(1'b0, 20'h00000, 32'h0);
        check("mode_srst", rd, 32'h00000001);
        bus(1'b0, 20'h00010, 32'h0);
        check("status_srst", rd, 32'h00000000);
        wrap_up();
    end
endmodule : testbench
